// ### include/sic_pkg.sv
/*
  Constants shared by the scanned input conditioner: register offsets,
  field positions, reset values and timing counts.
  Assumes a single 25 MHz core clock.
*/
package sic_pkg;
  // clock and time base
  localparam int SIC_CLK_HZ = 25_000_000;
  localparam int SIC_MS_TIME = 1;
  localparam int SIC_MS_CYCLES = SIC_CLK_HZ / 1000 * SIC_MS_TIME;
  localparam int SIC_SCAN_TIME_MS = 5;
  localparam int SIC_AC_DROP_MS = 30;

  // sizes
  localparam int SIC_MAX_INPUTS = 3;
  localparam int SIC_NUM_RELAYS = 5;
  localparam int SIC_DLY_W = 21;
  localparam int SIC_ADDR_W = 8;
  localparam int SIC_DATA_W = 32;

  // register byte offsets
  localparam logic [7:0] SIC_OFF_CTRL = 8'h00;
  localparam logic [7:0] SIC_OFF_RELAY_CMD = 8'h04;
  localparam logic [7:0] SIC_OFF_RELAY_ROUTE = 8'h08;
  localparam logic [7:0] SIC_OFF_STATUS = 8'h0C;
  localparam logic [7:0] SIC_OFF_PICKUP_BASE = 8'h10;
  localparam logic [7:0] SIC_OFF_DROP_BASE = 8'h14;
  localparam logic [7:0] SIC_OFF_CHAN_STRIDE = 8'h08;

  // field positions
  localparam int SIC_CTRL_SENSE_LSB = 0;
  localparam int SIC_CTRL_AC_LSB = 8;
  localparam int SIC_ST_RAW_LSB = 0;
  localparam int SIC_ST_COND_LSB = 4;
  localparam int SIC_ST_INT_LSB = 8;
  localparam int SIC_ST_RELAY_LSB = 16;
  localparam int SIC_ST_FAULT_BIT = 24;
  localparam int SIC_ST_FITTED_LSB = 28;

  // reset values
  localparam logic [2:0] SIC_RST_SENSE_NC = 3'h0;
  localparam logic [2:0] SIC_RST_AC_EN = 3'h0;
  localparam logic [20:0] SIC_RST_DELAY = 21'h000000;
  localparam logic [4:0] SIC_RST_RELAY_CMD = 5'h00;
  localparam logic [9:0] SIC_RST_RELAY_ROUTE = 10'h000;
endpackage : sic_pkg

// ### include/sic_chan_if.sv
/*
  Bundle between the conditioner top and one input channel: settings in,
  sampled and conditioned states out. Assumes one clock domain.
*/
`timescale 1ns/1ns
interface sic_chan_if;
  logic pin;
  logic sense_nc;
  logic ac_en;
  logic [20:0] pickup_ms;
  logic [20:0] drop_ms;
  logic scan_tick;
  logic ms_tick;
  logic raw;
  logic cond;

  modport chan (
    input pin,
    input sense_nc,
    input ac_en,
    input pickup_ms,
    input drop_ms,
    input scan_tick,
    input ms_tick,
    output raw,
    output cond
  );
  modport ctrl (
    output pin,
    output sense_nc,
    output ac_en,
    output pickup_ms,
    output drop_ms,
    output scan_tick,
    output ms_tick,
    input raw,
    input cond
  );
endinterface : sic_chan_if

// ### rtl/sic_tick_gen.sv
/*
  Divider producing a one-cycle millisecond enable and a scan enable
  every five milliseconds. Assumes core_clk at the package rate.
*/
`timescale 1ns/1ns
module sic_tick_gen #(
  parameter int MS_CYCLES = sic_pkg::SIC_MS_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  output logic ms_tick,
  output logic scan_tick
);
  logic [15:0] ms_cnt;
  logic [2:0] scan_cnt;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ms_cnt <= 16'h0000;
    end else if (ms_cnt == 16'(MS_CYCLES - 1)) begin
      ms_cnt <= 16'h0000;
    end else begin
      ms_cnt <= ms_cnt + 16'h0001;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      scan_cnt <= 3'h0;
    end else if (ms_tick) begin
      if (scan_cnt == 3'(sic_pkg::SIC_SCAN_TIME_MS - 1)) begin
        scan_cnt <= 3'h0;
      end else begin
        scan_cnt <= scan_cnt + 3'h1;
      end
    end
  end

  assign ms_tick = !rst && (ms_cnt == 16'(MS_CYCLES - 1));
  // scan rides on a ms tick so both align
  assign scan_tick = ms_tick && (scan_cnt == 3'(sic_pkg::SIC_SCAN_TIME_MS - 1));

  // helper: cycles since last scan tick
  logic [19:0] gap;
  always_ff @(posedge core_clk) begin
    if (rst || scan_tick) begin
      gap <= 20'h00000;
    end else begin
      gap <= gap + 20'h00001;
    end
  end

  a_scan_period: assert property (@(posedge core_clk) disable iff (rst)
    scan_tick |-> gap == 20'(MS_CYCLES * sic_pkg::SIC_SCAN_TIME_MS - 1)
      || $past(rst))
    else $error("scan tick spacing wrong");
endmodule : sic_tick_gen

// ### rtl/sic_input_chan.sv
/*
  One binary input: scan sampling with sense selection, then pick-up and
  drop-off qualification timed in milliseconds, with optional AC stretch.
  Assumes scan and ms enables from the shared divider.
*/
`timescale 1ns/1ns
module sic_input_chan (
  input wire logic core_clk,
  input wire logic rst,
  sic_chan_if.chan ch
);
  logic [20:0] cnt;
  logic [20:0] target;

  // sense applied at sampling; energized pin reads 1 when normally open
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ch.raw <= 1'b0;
    end else if (ch.scan_tick) begin
      ch.raw <= ch.pin ^ ch.sense_nc;
    end
  end

  // ac stretch only lengthens the release direction
  always_comb begin
    if (ch.raw) begin
      target = ch.pickup_ms;
    end else if (ch.ac_en) begin
      target = ch.drop_ms + 21'(sic_pkg::SIC_AC_DROP_MS);
    end else begin
      target = ch.drop_ms;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || ch.raw == ch.cond) begin
      cnt <= 21'h000000;
    end else if (ch.ms_tick && cnt < target) begin
      cnt <= cnt + 21'h000001;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ch.cond <= 1'b0;
    end else if (ch.raw != ch.cond && cnt >= target) begin
      ch.cond <= ch.raw;
    end
  end

  a_timer_restart: assert property (@(posedge core_clk) disable iff (rst)
    ch.raw == ch.cond |=> cnt == 21'h000000)
    else $error("qualify timer not cleared on stable level");
  a_cond_qualified: assert property (@(posedge core_clk) disable iff (rst)
    $changed(ch.cond) |-> ch.cond == $past(ch.raw)
      && $past(cnt) >= $past(target))
    else $error("conditioned state changed before delay ran out");
  a_zero_delay: assert property (@(posedge core_clk) disable iff (rst)
    ch.raw != ch.cond && target == 21'h000000 |=> ch.cond == $past(ch.raw))
    else $error("zero delay did not pass through");
  a_ac_stretch: assert property (@(posedge core_clk) disable iff (rst)
    ch.ac_en && !ch.raw && ch.cond && cnt < 21'(sic_pkg::SIC_AC_DROP_MS)
      |=> ch.cond)
    else $error("ac input dropped before stretch ended");
  c_pickup_done: cover property (@(posedge core_clk) disable iff (rst)
    $rose(ch.cond));
endmodule : sic_input_chan

// ### rtl/sic_scanned_input_conditioner.sv
/*
  Top of the scanned input conditioner: register port, per-input
  conditioning, internal state stage, output relay refresh and the
  fault-signalling relay.
  Assumes a 25 MHz core_clk, synchronous active-high reset, field inputs
  synchronous to the clock and a register master that never waits.
*/
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
// Summary of operation
// - every input is sampled once per 5 ms scan tick.
// - sense bit selects normally-open or normally-closed; open after reset.
// - rising conditioned state waits a pick-up delay in 1 ms steps.
// - falling conditioned state waits a separate drop-off delay in 1 ms steps.
// - AC mode adds a fixed 30 ms to the release delay.
// - internally used inputs take effect one scan after conditioning.
// - relays driven by inputs change one further scan later.
// - all relay outputs refresh together once per 5 ms scan.
// - fault relay energized only while powered and free of faults.
// - two or three inputs fitted by build option, one channel each.
module sic_scanned_input_conditioner #(
  parameter int NUM_INPUTS = 3,
  parameter int MS_CYCLES = sic_pkg::SIC_MS_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [2:0] binary_input_n,
  input wire logic sys_fault,
  output logic [4:0] relay_output_n,
  output logic fault_relay_energize,
  output logic [2:0] internal_input
);
  logic ms_tick;
  logic scan_tick;
  logic [2:0] sense_nc;
  logic [2:0] ac_en;
  logic [20:0] pickup_ms [3];
  logic [20:0] drop_ms [3];
  logic [4:0] relay_cmd;
  logic [9:0] relay_route;
  logic [2:0] raw;
  logic [2:0] cond;
  logic [4:0] next_relay;
  logic [31:0] next_rdata;

  // channel number hit by an address within a delay bank, 3 when none
  function automatic logic [1:0] sic_delay_hit(
    input logic [7:0] addr,
    input logic [7:0] base
  );
    logic [1:0] hit;
    hit = 2'h3;
    for (int i = 0; i < NUM_INPUTS; i++) begin
      if (addr == base + 8'(i * sic_pkg::SIC_OFF_CHAN_STRIDE)) begin
        hit = 2'(i);
      end
    end
    return hit;
  endfunction : sic_delay_hit

  sic_tick_gen #(
    .MS_CYCLES(MS_CYCLES)
  ) u_tick (
    .core_clk(core_clk),
    .rst(rst),
    .ms_tick(ms_tick),
    .scan_tick(scan_tick)
  );

  sic_chan_if ch [NUM_INPUTS] ();

  // one conditioning channel per fitted input
  for (genvar g = 0; g < sic_pkg::SIC_MAX_INPUTS; g++) begin : g_chan
    if (g < NUM_INPUTS) begin : g_fit
      assign ch[g].pin = binary_input_n[g];
      assign ch[g].sense_nc = sense_nc[g];
      assign ch[g].ac_en = ac_en[g];
      assign ch[g].pickup_ms = pickup_ms[g];
      assign ch[g].drop_ms = drop_ms[g];
      assign ch[g].scan_tick = scan_tick;
      assign ch[g].ms_tick = ms_tick;
      assign raw[g] = ch[g].raw;
      assign cond[g] = ch[g].cond;
      sic_input_chan u_chan (
        .core_clk(core_clk),
        .rst(rst),
        .ch(ch[g])
      );
    end else begin : g_empty
      // unfitted position reads inactive
      assign raw[g] = 1'b0;
      assign cond[g] = 1'b0;
    end
  end

  // control register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sense_nc <= sic_pkg::SIC_RST_SENSE_NC;
      ac_en <= sic_pkg::SIC_RST_AC_EN;
    end else if (reg_wr && reg_addr == sic_pkg::SIC_OFF_CTRL) begin
      sense_nc <= reg_wdata[sic_pkg::SIC_CTRL_SENSE_LSB +: 3];
      ac_en <= reg_wdata[sic_pkg::SIC_CTRL_AC_LSB +: 3];
    end
  end

  // delay settings, counted in milliseconds
  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int i = 0; i < 3; i++) begin
        pickup_ms[i] <= sic_pkg::SIC_RST_DELAY;
        drop_ms[i] <= sic_pkg::SIC_RST_DELAY;
      end
    end else if (reg_wr) begin
      if (sic_delay_hit(reg_addr, sic_pkg::SIC_OFF_PICKUP_BASE) != 2'h3) begin
        pickup_ms[sic_delay_hit(reg_addr, sic_pkg::SIC_OFF_PICKUP_BASE)]
          <= reg_wdata[20:0];
      end
      if (sic_delay_hit(reg_addr, sic_pkg::SIC_OFF_DROP_BASE) != 2'h3) begin
        drop_ms[sic_delay_hit(reg_addr, sic_pkg::SIC_OFF_DROP_BASE)]
          <= reg_wdata[20:0];
      end
    end
  end

  // relay command and routing
  always_ff @(posedge core_clk) begin
    if (rst) begin
      relay_cmd <= sic_pkg::SIC_RST_RELAY_CMD;
    end else if (reg_wr && reg_addr == sic_pkg::SIC_OFF_RELAY_CMD) begin
      relay_cmd <= reg_wdata[4:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      relay_route <= sic_pkg::SIC_RST_RELAY_ROUTE;
    end else if (reg_wr && reg_addr == sic_pkg::SIC_OFF_RELAY_ROUTE) begin
      relay_route <= reg_wdata[9:0];
    end
  end

  // internal consumers see the conditioned state a scan later
  always_ff @(posedge core_clk) begin
    if (rst) begin
      internal_input <= 3'h0;
    end else if (scan_tick) begin
      internal_input <= cond;
    end
  end

  // route 0 takes the software command, 1..3 an internal input
  always_comb begin
    next_relay = 5'h00;
    for (int r = 0; r < sic_pkg::SIC_NUM_RELAYS; r++) begin
      case (relay_route[2 * r +: 2])
        2'h0: next_relay[r] = relay_cmd[r];
        2'h1: next_relay[r] = internal_input[0];
        2'h2: next_relay[r] = internal_input[1];
        2'h3: next_relay[r] = internal_input[2];
        default: next_relay[r] = 1'b0;
      endcase
    end
  end

  // all relays move together so contacts never lag each other
  always_ff @(posedge core_clk) begin
    if (rst) begin
      relay_output_n <= 5'h00;
    end else if (scan_tick) begin
      relay_output_n <= next_relay;
    end
  end

  // held released in reset, which stands in for loss of power
  always_ff @(posedge core_clk) begin
    if (rst) begin
      fault_relay_energize <= 1'b0;
    end else begin
      fault_relay_energize <= !sys_fault;
    end
  end

  // register read, data valid only in the cycle after the strobe
  always_comb begin
    next_rdata = 32'h00000000;
    if (reg_addr == sic_pkg::SIC_OFF_CTRL) begin
      next_rdata[sic_pkg::SIC_CTRL_SENSE_LSB +: 3] = sense_nc;
      next_rdata[sic_pkg::SIC_CTRL_AC_LSB +: 3] = ac_en;
    end else if (reg_addr == sic_pkg::SIC_OFF_RELAY_CMD) begin
      next_rdata[4:0] = relay_cmd;
    end else if (reg_addr == sic_pkg::SIC_OFF_RELAY_ROUTE) begin
      next_rdata[9:0] = relay_route;
    end else if (reg_addr == sic_pkg::SIC_OFF_STATUS) begin
      next_rdata[sic_pkg::SIC_ST_RAW_LSB +: 3] = raw;
      next_rdata[sic_pkg::SIC_ST_COND_LSB +: 3] = cond;
      next_rdata[sic_pkg::SIC_ST_INT_LSB +: 3] = internal_input;
      next_rdata[sic_pkg::SIC_ST_RELAY_LSB +: 5] = relay_output_n;
      next_rdata[sic_pkg::SIC_ST_FAULT_BIT] = fault_relay_energize;
      next_rdata[sic_pkg::SIC_ST_FITTED_LSB +: 2] = 2'(NUM_INPUTS);
    end else if (sic_delay_hit(reg_addr, sic_pkg::SIC_OFF_PICKUP_BASE)
                 != 2'h3) begin
      next_rdata[20:0] =
        pickup_ms[sic_delay_hit(reg_addr, sic_pkg::SIC_OFF_PICKUP_BASE)];
    end else if (sic_delay_hit(reg_addr, sic_pkg::SIC_OFF_DROP_BASE)
                 != 2'h3) begin
      next_rdata[20:0] =
        drop_ms[sic_delay_hit(reg_addr, sic_pkg::SIC_OFF_DROP_BASE)];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

  // checks
  a_relay_refresh: assert property (@(posedge core_clk) disable iff (rst)
    scan_tick |=> relay_output_n == $past(next_relay))
    else $error("relays not refreshed on scan");
  a_relay_hold: assert property (@(posedge core_clk) disable iff (rst)
    !scan_tick |=> $stable(relay_output_n))
    else $error("relay moved between scans");
  a_internal_stage: assert property (@(posedge core_clk) disable iff (rst)
    $changed(internal_input) |-> $past(scan_tick)
      && internal_input == $past(cond))
    else $error("internal state not staged on scan");
  a_fault_drop: assert property (@(posedge core_clk) disable iff (rst)
    sys_fault |=> !fault_relay_energize)
    else $error("fault relay stayed energized on fault");
  a_fault_clear: assert property (@(posedge core_clk) disable iff (rst)
    !sys_fault ##1 !sys_fault |-> fault_relay_energize)
    else $error("fault relay not energized while healthy");
  a_sense_reset: assert property (@(posedge core_clk)
    rst |=> sense_nc == 3'h0 && ac_en == 3'h0)
    else $error("sense or ac not at default after reset");
  a_raw_on_scan: assert property (@(posedge core_clk) disable iff (rst)
    $changed(raw) |-> $past(scan_tick))
    else $error("raw state changed off the scan tick");
  a_read_one_cycle: assert property (@(posedge core_clk) disable iff (rst)
    !reg_rd |=> reg_rdata == 32'h00000000)
    else $error("read data outside its cycle");
  a_unfitted_quiet: assert property (@(posedge core_clk) disable iff (rst)
    NUM_INPUTS == 2 |-> !raw[2] && !cond[2])
    else $error("unfitted input active");

  c_route_input: cover property (@(posedge core_clk) disable iff (rst)
    relay_route[1:0] != 2'h0 && $rose(relay_output_n[0]));
  c_fault_event: cover property (@(posedge core_clk) disable iff (rst)
    $fell(fault_relay_energize));
  c_nc_sense: cover property (@(posedge core_clk) disable iff (rst)
    sense_nc[0] && $rose(cond[0]));
  c_ac_release: cover property (@(posedge core_clk) disable iff (rst)
    ac_en[0] && $fell(cond[0]));
endmodule : sic_scanned_input_conditioner

// ### bench/sic_field_model.sv
/*
  Field side of the conditioner: contacts feeding the binary inputs and
  switchgear following the relay drives.
  Assumes contacts settle synchronous to core_clk.
*/
`timescale 1ns/1ns
module sic_field_model (
  input wire logic core_clk,
  input wire logic [2:0] contact_cmd,
  input wire logic [4:0] relay_output_n,
  input wire logic fault_relay_energize,
  output logic [2:0] binary_input_n,
  output logic [4:0] gear_closed,
  output logic gear_fault_contact
);
  initial binary_input_n = 3'h0;
  // one register stage, like an isolator settling after the clock edge
  always @(posedge core_clk) begin
    binary_input_n <= contact_cmd;
  end
  // fault contact closes whenever the coil is released, power loss too
  always_comb begin
    gear_closed = relay_output_n;
    gear_fault_contact = !fault_relay_energize;
  end
endmodule : sic_field_model

// ### bench/tb_scanned_input_conditioner.sv
/*
  Self-checking bench for the scanned input conditioner: register map,
  sense, scan latency, delays, relay refresh and fault relay.
  Assumes MS_CYCLES of 4, so one scan is 20 core_clk cycles.
*/
`timescale 1ns/1ns
module tb_scanned_input_conditioner;
  localparam int MS = 4;
  localparam int SCAN = MS * sic_pkg::SIC_SCAN_TIME_MS;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic sys_fault = 1'b0;
  logic [2:0] contact_cmd = 3'h0;
  logic [31:0] reg_rdata;
  logic [2:0] binary_input_n;
  logic [2:0] internal_input;
  logic [4:0] relay_output_n;
  logic fault_relay_energize;
  int num_errors = 0;
  int checks_done = 0;

  always #20 core_clk = ~core_clk;

  sic_scanned_input_conditioner #(.NUM_INPUTS(3), .MS_CYCLES(MS))
      sic_scanned_input_conditioner_inst (
    .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .binary_input_n(binary_input_n),
    .sys_fault(sys_fault), .relay_output_n(relay_output_n),
    .fault_relay_energize(fault_relay_energize),
    .internal_input(internal_input));

  sic_field_model sic_field_model_inst (
    .core_clk(core_clk), .contact_cmd(contact_cmd),
    .relay_output_n(relay_output_n),
    .fault_relay_energize(fault_relay_energize),
    .binary_input_n(binary_input_n), .gear_closed(),
    .gear_fault_contact());

  function automatic logic [2:0] exp_raw(logic [2:0] pin, logic [2:0] nc);
    return pin ^ nc;
  endfunction : exp_raw
  // window from contact change to internal state change
  function automatic int lat_lo(int ms);
    return (ms == 0) ? SCAN : (ms - 1) * MS + 2;
  endfunction : lat_lo
  function automatic int lat_hi(int ms);
    return ms * MS + 2 * SCAN + 3;
  endfunction : lat_hi

  task automatic test_done;
    $display("checks %0d, errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done

  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t %s: got %h want %h", $time, what, got, exp);
    end
  endtask : check

  task automatic check_win(input int got, input int lo, input int hi,
                           input string what);
    checks_done++;
    if (got < lo || got > hi) begin
      num_errors++;
      $display("ERROR %0t %s: %0d cycles, want %0d..%0d", $time, what,
               got, lo, hi);
    end
  endtask : check_win

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : reg_read

  // cycles until internal state or relays 0..2 reach want
  task automatic time_to(input bit on_relay, input logic [2:0] want,
                         input int lo, input int hi, input string what);
    int n;
    n = 0;
    #1;
    while ((on_relay ? relay_output_n[2:0] : internal_input) !== want
           && n <= hi + 5) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    check_win(n, lo, hi, what);
  endtask : time_to

  initial begin : main
    logic [31:0] d;
    logic [2:0] pin;
    logic [2:0] nc;
    logic [4:0] prev;
    logic glitch;
    int p;
    int q;
    void'($urandom(54));
    glitch = 1'b0;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    for (int a = 0; a <= 'h24; a += 4) begin
      reg_read(8'(a), d);
      check(d, (a == 'h0C) ? 32'h3100_0000 : 32'h0, "reset");
    end
    reg_read(8'h30, d);
    check(d, 32'h0, "unmapped");
    reg_write(sic_pkg::SIC_OFF_STATUS, 32'hFFFF_FFFF);
    reg_read(sic_pkg::SIC_OFF_STATUS, d);
    check(d, 32'h3100_0000, "status read only");
    $display("test reset_map done");
    @(posedge core_clk);
    sys_fault <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    check(fault_relay_energize, 1'b0, "fault drop");
    @(posedge core_clk);
    sys_fault <= 1'b0;
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    check(fault_relay_energize, 1'b0, "power loss");
    @(posedge core_clk);
    rst <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    check(fault_relay_energize, 1'b1, "healthy");
    $display("test fault_relay done");
    for (int i = 0; i < 6; i++) begin
      pin = 3'($urandom);
      nc = (i == 0) ? 3'h7 : 3'($urandom);
      reg_write(sic_pkg::SIC_OFF_CTRL, {29'h0, nc});
      @(posedge core_clk);
      contact_cmd <= pin;
      repeat (SCAN + 2) @(posedge core_clk);
      reg_read(sic_pkg::SIC_OFF_STATUS, d);
      check(d[2:0], exp_raw(pin, nc), "raw");
      repeat (2 * SCAN) @(posedge core_clk);
      #1;
      check(internal_input, exp_raw(pin, nc), "internal");
    end
    reg_write(sic_pkg::SIC_OFF_CTRL, 32'h0);
    contact_cmd <= 3'h0;
    repeat (4 * SCAN) @(posedge core_clk);
    $display("test sense done");
    // relays 0..2 follow internal inputs 0..2, relays 3..4 the command
    reg_write(sic_pkg::SIC_OFF_RELAY_ROUTE, 32'h0000_0039);
    repeat (2 * SCAN) @(posedge core_clk);
    for (int v = 0; v < 2; v++) begin
      @(posedge core_clk);
      contact_cmd <= v ? 3'h0 : 3'h7;
      fork
        time_to(1'b0, v ? 3'h0 : 3'h7, lat_lo(0), lat_hi(0), "lag");
        time_to(1'b1, v ? 3'h0 : 3'h7, lat_lo(0) + SCAN,
                lat_hi(0) + SCAN, "relay lag");
      join
    end
    $display("test latency done");
    reg_write(sic_pkg::SIC_OFF_RELAY_ROUTE, 32'h0);
    for (int i = 0; i < 4; i++) begin
      q = (i == 0) ? 'h1F : $urandom_range(31);
      reg_write(sic_pkg::SIC_OFF_RELAY_CMD, 32'(q));
      #1;
      prev = relay_output_n;
      p = 0;
      while (relay_output_n !== 5'(q) && p <= SCAN + 2) begin
        if (relay_output_n !== prev) begin
          check(relay_output_n, prev, "partial refresh");
        end
        @(posedge core_clk);
        #1;
        p++;
      end
      check_win(p, 0, SCAN + 1, "refresh");
    end
    $display("test relay_refresh done");
    for (int ch = 0; ch < 3; ch++) begin
      p = $urandom_range(20, 12);
      q = $urandom_range(20, 12);
      reg_write(8'(sic_pkg::SIC_OFF_PICKUP_BASE + ch * 8), 32'(p));
      reg_write(8'(sic_pkg::SIC_OFF_DROP_BASE + ch * 8), 32'(q));
      reg_write(sic_pkg::SIC_OFF_CTRL, (ch == 2) ? 32'h400 : 32'h0);
      reg_read(8'(sic_pkg::SIC_OFF_PICKUP_BASE + ch * 8), d);
      check(d, 32'(p), "pick-up reg");
      @(posedge core_clk);
      contact_cmd <= 3'(1 << ch);
      time_to(1'b0, 3'(1 << ch), lat_lo(p), lat_hi(p), "pick-up");
      @(posedge core_clk);
      contact_cmd <= 3'h0;
      if (ch == 2) q += sic_pkg::SIC_AC_DROP_MS;
      time_to(1'b0, 3'h0, lat_lo(q), lat_hi(q), "drop-off");
    end
    $display("test delays done");
    // two short pulses: together long enough, each alone too short
    reg_write(sic_pkg::SIC_OFF_PICKUP_BASE, 32'h0000_000C);
    fork
      repeat (2) begin
        @(posedge core_clk);
        contact_cmd <= 3'h1;
        repeat (30) @(posedge core_clk);
        contact_cmd <= 3'h0;
        repeat (30) @(posedge core_clk);
      end
      repeat (150) begin
        @(posedge core_clk);
        #1;
        if (internal_input !== 3'h0) glitch = 1'b1;
      end
    join
    check(glitch, 1'b0, "timer restart");
    $display("test restart done");
    test_done();
  end

  initial begin : watchdog
    repeat (20000) @(posedge core_clk);
    num_errors++;
    $display("ERROR %0t watchdog expired", $time);
    test_done();
  end
endmodule : tb_scanned_input_conditioner
